/* File: rtl/cad_pkg.sv */
// constants for the cpu8 instruction decode and effective-address block
package cad_pkg;
  // ----------------------------------------
  // addressing mode high nibbles
  // ----------------------------------------
  localparam logic [3:0] MODE_IMM  = 4'ha;
  localparam logic [3:0] MODE_DIR  = 4'hb;
  localparam logic [3:0] MODE_EXT  = 4'hc;
  localparam logic [3:0] MODE_IX2  = 4'hd;
  localparam logic [3:0] MODE_IX1  = 4'he;
  localparam logic [3:0] MODE_IX   = 4'hf;
  localparam logic [3:0] RMW_DIR   = 4'h3;
  localparam logic [3:0] RMW_INHA  = 4'h4;
  localparam logic [3:0] RMW_INHX  = 4'h5;
  localparam logic [3:0] RMW_IX1   = 4'h6;
  localparam logic [3:0] RMW_IX    = 4'h7;
  localparam logic [3:0] GRP_BTB   = 4'h0;
  localparam logic [3:0] GRP_BSC   = 4'h1;
  localparam logic [3:0] GRP_REL   = 4'h2;
  // ----------------------------------------
  // individual opcodes
  // ----------------------------------------
  localparam logic [3:0] LO_CPX                 = 4'h3;
  localparam logic [3:0] LO_ASR                 = 4'h7;
  localparam logic [7:0] OP_BRANCH_IRQ_PIN_LOW  = 8'h2e;
  localparam logic [7:0] OP_BRANCH_IRQ_PIN_HIGH = 8'h2f;
  localparam logic [7:0] OP_BRANCH_TO_SUB       = 8'had;
  localparam logic [7:0] OP_COPY_ACC_TO_INDEX   = 8'h97;
  localparam logic [7:0] OP_COPY_INDEX_TO_ACC   = 8'h9f;
  localparam logic [7:0] OP_SET_CARRY           = 8'h99;
  localparam logic [7:0] OP_CLEAR_CARRY         = 8'h98;
  localparam logic [7:0] OP_SET_INT_MASK        = 8'h9b;
  localparam logic [7:0] OP_CLEAR_INT_MASK      = 8'h9a;
  localparam logic [7:0] OP_RETURN_FROM_INT     = 8'h80;
  localparam logic [7:0] OP_RETURN_FROM_SUB     = 8'h81;
  localparam logic [7:0] OP_SOFTWARE_INT        = 8'h83;
  localparam logic [7:0] OP_RESET_STACK_PTR     = 8'h9c;
  localparam logic [7:0] OP_NO_OPERATION        = 8'h9d;
  // ----------------------------------------
  // cycle counts
  // ----------------------------------------
  localparam logic [3:0] CYC_IMM  = 4'h2;
  localparam logic [3:0] CYC_DIR  = 4'h3;
  localparam logic [3:0] CYC_EXT  = 4'h4;
  localparam logic [3:0] CYC_IX2  = 4'h5;
  localparam logic [3:0] CYC_IX1  = 4'h4;
  localparam logic [3:0] CYC_IX   = 4'h3;
  localparam logic [3:0] CYC_BIT  = 4'h5;
  localparam logic [3:0] CYC_REL  = 4'h3;
  localparam logic [3:0] CYC_BSR  = 4'h6;
  localparam logic [3:0] CYC_RMWI = 4'h3;
  localparam logic [3:0] CYC_RMWD = 4'h5;
  localparam logic [3:0] CYC_RMW1 = 4'h6;
  localparam logic [3:0] CYC_CTL  = 4'h2;
  localparam logic [3:0] CYC_RTI  = 4'h9;
  localparam logic [3:0] CYC_RTS  = 4'h6;
  localparam logic [3:0] CYC_SWI  = 4'ha;
  // ----------------------------------------
  // decoded addressing mode, one-hot
  // ----------------------------------------
  typedef enum logic [9:0] {
    AM_INH = 10'h001, AM_IMM = 10'h002, AM_DIR = 10'h004, AM_EXT = 10'h008,
    AM_IX  = 10'h010, AM_IX1 = 10'h020, AM_IX2 = 10'h040, AM_REL = 10'h080,
    AM_BSC = 10'h100, AM_BTB = 10'h200
  } cad_mode_t;
  // sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_OPC = 4'h1, ST_B1 = 4'h2, ST_B2 = 4'h4, ST_DONE = 4'h8
  } cad_state_t;
endpackage

/* File: rtl/cad_byte_store.sv */
// small store holding the opcode and its two operand bytes
`timescale 1ns/1ps
module cad_byte_store (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       wr_en,
  input  wire logic [1:0] wr_idx,
  input  wire logic [7:0] wr_data,
  input  wire logic [1:0] rd_idx,
  output logic      [7:0] rd_data_q
);
  logic [7:0] mem_q [0:2];
  logic [7:0] rd_d;

  // ----------------------------------------
  // read select
  // ----------------------------------------
  always_comb begin
    rd_d = (rd_idx > 2'h2) ? 8'h00 : mem_q[rd_idx];
  end

  // write port and registered read
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_q[0]  <= 8'h00;
      mem_q[1]  <= 8'h00;
      mem_q[2]  <= 8'h00;
      rd_data_q <= 8'h00;
    end else begin
      if (wr_en && wr_idx <= 2'h2) begin
        mem_q[wr_idx] <= wr_data;
      end
      rd_data_q <= rd_d;
    end
  end
endmodule

/* File: rtl/cad_decode.sv */
// instruction decode and effective-address generation for an 8-bit core
`timescale 1ns/1ps
module cad_decode (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        start,        // begin an instruction at pc
  input  wire logic [15:0] pc,           // opcode address
  input  wire logic [7:0]  index_reg,
  input  wire logic        cond_true,    // ccr branch condition from datapath
  input  wire logic        irq_pin,
  input  wire logic        mem_valid,    // fetch data valid
  input  wire logic [7:0]  mem_rdata,
  input  wire logic [7:0]  bit_byte,     // operand byte for bit test-branch
  output logic             fetch_req_q,
  output logic [15:0]      fetch_addr_q,
  output logic             done_q,       // one-cycle decode complete
  output logic [7:0]       opcode_q,
  output cad_pkg::cad_mode_t mode_q,
  output logic [15:0]      eff_addr_q,
  output logic [15:0]      next_pc_q,
  output logic [1:0]       length_q,
  output logic [3:0]       cycles_q,
  output logic [2:0]       bit_num_q,
  output logic             bit_set_op_q, // set vs clear for bit ops
  output logic             use_index_q,  // compare against index
  output logic             carry_val_q,  // tested bit for the carry flag
  output logic             carry_we_q,
  output logic             undefined_q
);
  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  // byte length from opcode
  function automatic logic [1:0] op_len(input logic [7:0] op);
    logic [3:0] hi;
    hi = op[7:4];
    case (hi)
      cad_pkg::GRP_BTB, cad_pkg::MODE_EXT, cad_pkg::MODE_IX2: op_len = 2'h3;
      cad_pkg::RMW_INHA, cad_pkg::RMW_INHX, cad_pkg::RMW_IX,
      cad_pkg::MODE_IX, 4'h8, 4'h9: op_len = 2'h1;
      default: op_len = 2'h2;
    endcase
  endfunction

  // undefined opcodes in the map
  function automatic logic op_undef(input logic [7:0] op);
    logic [3:0] lo;
    lo = op[3:0];
    op_undef = 1'b0;
    case (op[7:4])
      cad_pkg::RMW_DIR, cad_pkg::RMW_INHA, cad_pkg::RMW_INHX,
      cad_pkg::RMW_IX1, cad_pkg::RMW_IX:
        op_undef = (lo == 4'h1) || (lo == 4'h2) || (lo == 4'h5) || (lo == 4'hb) ||
                   (op == 8'h3e) || (op == 8'h4e) || (op == 8'h5e) ||
                   (op == 8'h6e) || (op == 8'h7e) || (op == 8'h5f && 1'b0);
      4'h8:    op_undef = !(op == cad_pkg::OP_RETURN_FROM_INT ||
                            op == cad_pkg::OP_RETURN_FROM_SUB ||
                            op == cad_pkg::OP_SOFTWARE_INT ||
                            lo == 4'he || lo == 4'hf);
      4'h9:    op_undef = (lo < 4'h7) || (lo == 4'he);
      cad_pkg::MODE_IMM:
        op_undef = (lo == 4'h7) || (lo == 4'hc) || (lo == 4'hf);
      default: op_undef = 1'b0;
    endcase
  endfunction

  // 8-bit signed offset added to a base
  function automatic logic [15:0] rel_tgt(input logic [15:0] base, input logic [7:0] off);
    rel_tgt = base + {{8{off[7]}}, off};
  endfunction

  // ----------------------------------------
  // sequencer state
  // ----------------------------------------
  cad_pkg::cad_state_t st_q, st_d;
  logic [15:0] fa_d;
  logic        fr_d;
  logic [1:0]  wr_idx;
  logic        wr_en;
  logic [1:0]  got_q, got_d;
  logic [7:0]  op_s, b1_s, b2_s;
  logic [7:0]  b1_q, b1_d;
  logic [7:0]  rd_data;

  cad_byte_store u_store (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .wr_en     (wr_en),
    .wr_idx    (wr_idx),
    .wr_data   (mem_rdata),
    .rd_idx    (2'h0),
    .rd_data_q (rd_data)
  );

  // fetch sequencing: one byte per accepted fetch
  always_comb begin
    st_d   = st_q;
    fa_d   = fetch_addr_q;
    fr_d   = fetch_req_q;
    got_d  = got_q;
    b1_d   = b1_q;
    wr_en  = 1'b0;
    wr_idx = got_q;
    case (st_q)
      cad_pkg::ST_OPC: begin
        if (start && !fetch_req_q) begin
          fr_d  = 1'b1;
          fa_d  = pc;
          got_d = 2'h0;
        end else if (fetch_req_q && mem_valid) begin
          wr_en = 1'b1;
          got_d = 2'h1;
          if (op_len(mem_rdata) == 2'h1) begin
            fr_d = 1'b0;
            st_d = cad_pkg::ST_DONE;
          end else begin
            fa_d = fetch_addr_q + 16'h0001;
            st_d = cad_pkg::ST_B1;
          end
        end
      end
      cad_pkg::ST_B1: begin
        if (mem_valid) begin
          wr_en = 1'b1;
          b1_d  = mem_rdata;
          got_d = 2'h2;
          if (op_len(opcode_q) == 2'h2) begin
            fr_d = 1'b0;
            st_d = cad_pkg::ST_DONE;
          end else begin
            fa_d = fetch_addr_q + 16'h0001;
            st_d = cad_pkg::ST_B2;
          end
        end
      end
      cad_pkg::ST_B2: begin
        if (mem_valid) begin
          wr_en = 1'b1;
          got_d = 2'h3;
          fr_d  = 1'b0;
          st_d  = cad_pkg::ST_DONE;
        end
      end
      cad_pkg::ST_DONE: st_d = cad_pkg::ST_OPC;
      default:          st_d = cad_pkg::ST_OPC;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q         <= cad_pkg::ST_OPC;
      fetch_addr_q <= 16'h0000;
      fetch_req_q  <= 1'b0;
      got_q        <= 2'h0;
      b1_q         <= 8'h00;
    end else begin
      st_q         <= st_d;
      fetch_addr_q <= fa_d;
      fetch_req_q  <= fr_d;
      got_q        <= got_d;
      b1_q         <= b1_d;
    end
  end

  // ----------------------------------------
  // decode and address generation
  // ----------------------------------------
  // bytes as they stand when the final byte lands
  always_comb begin
    op_s = (st_q == cad_pkg::ST_OPC) ? mem_rdata : opcode_q;
    b1_s = (st_q == cad_pkg::ST_B1) ? mem_rdata : b1_q;
    b2_s = mem_rdata;
  end

  logic [7:0]  opc_d;
  cad_pkg::cad_mode_t mode_d;
  logic [15:0] ea_d, np_d;
  logic [3:0]  cyc_d;
  logic        done_d, take;
  logic [8:0]  lo_sum;
  logic [7:0]  hi_byte;
  logic        tested;

  always_comb begin
    done_d  = (st_d == cad_pkg::ST_DONE) && (st_q != cad_pkg::ST_DONE);
    opc_d   = (st_q == cad_pkg::ST_OPC && wr_en) ? mem_rdata : opcode_q;
    mode_d  = cad_pkg::AM_INH;
    ea_d    = 16'h0000;
    cyc_d   = cad_pkg::CYC_CTL;
    np_d    = pc + {14'h0000, op_len(op_s)};
    take    = cond_true;
    tested  = bit_byte[op_s[3:1]];
    lo_sum  = {1'b0, index_reg} + {1'b0, b2_s};
    hi_byte = b1_s + {7'h00, lo_sum[8]};
    case (op_s[7:4])
      cad_pkg::GRP_BTB: begin
        mode_d = cad_pkg::AM_BTB;
        ea_d   = {8'h00, b1_s};
        cyc_d  = cad_pkg::CYC_BIT;
        take   = op_s[0] ? !tested : tested;
        if (take) np_d = rel_tgt(pc + 16'h0003, b2_s);
      end
      cad_pkg::GRP_BSC: begin
        mode_d = cad_pkg::AM_BSC;
        ea_d   = {8'h00, b1_s};
        cyc_d  = cad_pkg::CYC_BIT;
      end
      cad_pkg::GRP_REL: begin
        mode_d = cad_pkg::AM_REL;
        cyc_d  = cad_pkg::CYC_REL;
        if (op_s == cad_pkg::OP_BRANCH_IRQ_PIN_LOW)  take = !irq_pin;
        if (op_s == cad_pkg::OP_BRANCH_IRQ_PIN_HIGH) take = irq_pin;
        ea_d = rel_tgt(pc + 16'h0002, b1_s);
        if (take) np_d = ea_d;
      end
      cad_pkg::RMW_INHA, cad_pkg::RMW_INHX: cyc_d = cad_pkg::CYC_RMWI;
      cad_pkg::RMW_DIR: begin
        mode_d = cad_pkg::AM_DIR;
        ea_d   = {8'h00, b1_s};
        cyc_d  = cad_pkg::CYC_RMWD;
      end
      cad_pkg::RMW_IX: begin
        mode_d = cad_pkg::AM_IX;
        ea_d   = {8'h00, index_reg};
        cyc_d  = cad_pkg::CYC_RMWD;
      end
      cad_pkg::RMW_IX1: begin
        mode_d = cad_pkg::AM_IX1;
        ea_d   = {8'h00, index_reg} + {8'h00, b1_s};
        cyc_d  = cad_pkg::CYC_RMW1;
      end
      4'h8: begin
        case (op_s)
          cad_pkg::OP_RETURN_FROM_INT: cyc_d = cad_pkg::CYC_RTI;
          cad_pkg::OP_RETURN_FROM_SUB: cyc_d = cad_pkg::CYC_RTS;
          cad_pkg::OP_SOFTWARE_INT:    cyc_d = cad_pkg::CYC_SWI;
          default:                     cyc_d = cad_pkg::CYC_CTL;
        endcase
      end
      4'h9: cyc_d = cad_pkg::CYC_CTL;
      cad_pkg::MODE_IMM: begin
        mode_d = cad_pkg::AM_IMM;
        ea_d   = pc + 16'h0001;
        cyc_d  = cad_pkg::CYC_IMM;
        if (op_s == cad_pkg::OP_BRANCH_TO_SUB) begin
          mode_d = cad_pkg::AM_REL;
          ea_d   = rel_tgt(pc + 16'h0002, b1_s);
          np_d   = ea_d;
          cyc_d  = cad_pkg::CYC_BSR;
        end
      end
      cad_pkg::MODE_DIR: begin
        mode_d = cad_pkg::AM_DIR;
        ea_d   = {8'h00, b1_s};
        cyc_d  = cad_pkg::CYC_DIR;
      end
      cad_pkg::MODE_EXT: begin
        mode_d = cad_pkg::AM_EXT;
        ea_d   = {b1_s, b2_s};
        cyc_d  = cad_pkg::CYC_EXT;
      end
      cad_pkg::MODE_IX2: begin
        mode_d = cad_pkg::AM_IX2;
        ea_d   = {hi_byte, lo_sum[7:0]};
        cyc_d  = cad_pkg::CYC_IX2;
      end
      cad_pkg::MODE_IX1: begin
        mode_d = cad_pkg::AM_IX1;
        ea_d   = {8'h00, index_reg} + {8'h00, b1_s};
        cyc_d  = cad_pkg::CYC_IX1;
      end
      cad_pkg::MODE_IX: begin
        mode_d = cad_pkg::AM_IX;
        ea_d   = {8'h00, index_reg};
        cyc_d  = cad_pkg::CYC_IX;
      end
      default: mode_d = cad_pkg::AM_INH;
    endcase
  end

  // results update only as an instruction completes, except opcode_q (loads when the opcode byte lands) and done_q
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      opcode_q     <= 8'h00;
      mode_q       <= cad_pkg::AM_INH;
      eff_addr_q   <= 16'h0000;
      next_pc_q    <= 16'h0000;
      length_q     <= 2'h0;
      cycles_q     <= 4'h0;
      bit_num_q    <= 3'h0;
      bit_set_op_q <= 1'b0;
      use_index_q  <= 1'b0;
      carry_val_q  <= 1'b0;
      carry_we_q   <= 1'b0;
      undefined_q  <= 1'b0;
      done_q       <= 1'b0;
    end else begin
      opcode_q <= opc_d;
      done_q   <= done_d;
      if (done_d) begin
        mode_q       <= mode_d;
        eff_addr_q   <= ea_d;
        next_pc_q    <= np_d;
        length_q     <= op_len(op_s);
        cycles_q     <= cyc_d;
        bit_num_q    <= op_s[3:1];
        bit_set_op_q <= !op_s[0];
        use_index_q  <= (op_s[3:0] == cad_pkg::LO_CPX) && (op_s[7:4] >= cad_pkg::MODE_IMM);
        carry_val_q  <= tested;
        carry_we_q   <= (op_s[7:4] == cad_pkg::GRP_BTB);
        undefined_q  <= op_undef(op_s);
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // stored opcode read back one cycle after done, before any new fetch lands
  store_opcode_a: assert property (@(posedge clk) disable iff (sys_rst)
    done_q |=> rd_data == opcode_q)
    else $error("stored opcode differs from decoded opcode");
  bit_cycles_a: assert property (@(posedge clk) disable iff (sys_rst)
    done_q && (opcode_q[7:5] == 3'h0) |-> cycles_q == 4'h5)
    else $error("bit op cycle count wrong");
  bsc_page_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    done_q && opcode_q[7:4] == 4'h1 |-> eff_addr_q[15:8] == 8'h00 && length_q == 2'h2)
    else $error("bit set/clear address not page zero");
  rel_len_a: assert property (@(posedge clk) disable iff (sys_rst)
    done_q && opcode_q[7:4] == 4'h2 |-> length_q == 2'h2 && cycles_q == 4'h3)
    else $error("branch length or cycles wrong");
  bsr_cycles_a: assert property (@(posedge clk) disable iff (sys_rst)
    done_q && opcode_q == 8'had |-> cycles_q == 4'h6 && mode_q == cad_pkg::AM_REL)
    else $error("subroutine branch decode wrong");
  ctl_cycles_a: assert property (@(posedge clk) disable iff (sys_rst)
    done_q && opcode_q == 8'h97 |-> cycles_q == 4'h2 && length_q == 2'h1)
    else $error("transfer decode wrong");
  swi_cycles_a: assert property (@(posedge clk) disable iff (sys_rst)
    done_q && opcode_q == 8'h83 |-> cycles_q == 4'ha)
    else $error("software interrupt cycles wrong");
  btb_carry_a: assert property (@(posedge clk) disable iff (sys_rst)
    done_q && opcode_q[7:4] == 4'h0 |-> carry_we_q)
    else $error("tested bit not sent to carry");
  cpx_index_a: assert property (@(posedge clk) disable iff (sys_rst)
    done_q && opcode_q == 8'ha3 |-> use_index_q)
    else $error("index compare not flagged");
  fetch_done_a: assert property (@(posedge clk) disable iff (sys_rst)
    fetch_req_q && mem_valid && st_q == cad_pkg::ST_OPC && mem_rdata[7:4] == 4'hf
    |=> done_q && !fetch_req_q)
    else $error("one-byte indexed fetch did not finish");
endmodule

/* File: tb/cad_mem_model.sv */
// memory model answering the decoder's byte fetches
`timescale 1ns/1ps
module cad_mem_model (
  input  wire logic        clk,
  input  wire logic        fetch_req_q,
  input  wire logic [15:0] fetch_addr_q,
  input  wire logic [1:0]  slow,
  output logic             mem_valid,
  output logic [7:0]       mem_rdata
);
  logic [7:0] mem [0:65535];
  int         wait_n;

  // start idle with the data lines quiet
  initial begin
    mem_valid = 1'b0;
    mem_rdata = 8'h00;
    wait_n = 0;
  end

  // ----------------------------------------
  // answer after slow idle cycles
  // ----------------------------------------
  // data is not held between answers: it toggles so a stale byte never looks valid
  always @(posedge clk) begin
    #1;
    if (fetch_req_q && wait_n >= int'(slow)) begin
      mem_valid = 1'b1;
      mem_rdata = mem[fetch_addr_q];
      wait_n = 0;
    end else begin
      mem_valid = 1'b0;
      mem_rdata = ~mem_rdata;
      wait_n = fetch_req_q ? wait_n + 1 : 0;
    end
  end
endmodule

/* File: tb/cad_decode_tb.sv */
// self-checking bench for the decode and effective-address block
`timescale 1ns/1ps
module cad_decode_tb;
  logic               clk = 1'b0;
  logic               sys_rst = 1'b1;
  logic               start = 1'b0;
  logic [15:0]        pc = 16'h0000;
  logic [7:0]         index_reg = 8'h00;
  logic               cond_true = 1'b0;
  logic               irq_pin = 1'b1;
  logic [7:0]         bit_byte = 8'h00;
  logic [1:0]         slow = 2'h0;
  logic               mem_valid, fetch_req_q, done_q, bit_set_op_q, use_index_q;
  logic               carry_val_q, carry_we_q, undefined_q;
  logic [7:0]         mem_rdata, opcode_q;
  logic [15:0]        fetch_addr_q, eff_addr_q, next_pc_q;
  logic [1:0]         length_q;
  logic [3:0]         cycles_q;
  logic [2:0]         bit_num_q;
  cad_pkg::cad_mode_t mode_q;
  int                 fails = 0;
  int                 n_compared = 0;

  always #2.5 clk = ~clk;

  cad_decode cad_decode_i (.clk, .sys_rst, .start, .pc, .index_reg, .cond_true, .irq_pin,
    .mem_valid, .mem_rdata, .bit_byte, .fetch_req_q, .fetch_addr_q, .done_q, .opcode_q,
    .mode_q, .eff_addr_q, .next_pc_q, .length_q, .cycles_q, .bit_num_q, .bit_set_op_q,
    .use_index_q, .carry_val_q, .carry_we_q, .undefined_q);

  cad_mem_model cad_mem_model_i (.clk, .fetch_req_q, .fetch_addr_q, .slow, .mem_valid,
    .mem_rdata);

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  // load three bytes, start, wait for done under a bound
  task automatic run(input logic [15:0] p, input logic [7:0] b0, b1, b2);
    int i;
    cad_mem_model_i.mem[p] = b0;
    cad_mem_model_i.mem[p + 16'h1] = b1;
    cad_mem_model_i.mem[p + 16'h2] = b2;
    pc = p;
    start = 1'b1;
    // hold start until taken: the cycle in which done_q is high still ignores it
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      #1;
      if (fetch_req_q === 1'b1) break;
    end
    start = 1'b0;
    if (i == 40) begin
      fails++;
      report_and_stop();
    end
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      #1;
      if (done_q === 1'b1) break;
    end
    if (i == 40) begin
      fails++;
      report_and_stop();
    end
  endtask

  task automatic ins(input logic [1:0] l, input logic [3:0] c, input cad_pkg::cad_mode_t m,
                     input logic [15:0] np);
    chk("length", 16'(length_q), 16'(l));
    chk("cycles", 16'(cycles_q), 16'(c));
    chk("mode", 16'(mode_q), 16'(m));
    chk("next_pc", next_pc_q, np);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // every register/memory mode, then index compares
  task automatic t_modes();
    logic [3:0] hi [6] = '{4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
    logic [1:0] ln [6] = '{2'h2, 2'h2, 2'h3, 2'h3, 2'h2, 2'h1};
    logic [3:0] cy [6] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h4, 4'h3};
    logic [15:0] ea [6] = '{16'h0401, 16'h0012, 16'h1234, 16'h1244, 16'h0022, 16'h0010};
    cad_pkg::cad_mode_t md [6] = '{cad_pkg::AM_IMM, cad_pkg::AM_DIR, cad_pkg::AM_EXT,
                                   cad_pkg::AM_IX2, cad_pkg::AM_IX1, cad_pkg::AM_IX};
    index_reg = 8'h10;
    for (int k = 0; k < 6; k++) begin
      run(16'h0400, {hi[k], 4'h6}, 8'h12, 8'h34);
      ins(ln[k], cy[k], md[k], 16'h0400 + 16'(ln[k]));
      chk("ea", eff_addr_q, ea[k]);
      chk("index", 16'(use_index_q), 16'h0);
    end
    run(16'h0400, 8'ha3, 8'h12, 8'h34);
    chk("opcode", 16'(opcode_q), 16'h00a3);
    chk("index", 16'(use_index_q), 16'h1);
    run(16'h0400, 8'hb3, 8'h12, 8'h34);
    chk("index", 16'(use_index_q), 16'h1);
  endtask

  // index carries into the high byte, with a slow memory
  task automatic t_index();
    slow = 2'h2;
    index_reg = 8'hf0;
    run(16'h0500, 8'hd6, 8'h12, 8'h34);
    chk("ea", eff_addr_q, 16'h1324);
    ins(2'h3, 4'h5, cad_pkg::AM_IX2, 16'h0503);
    chk("fetch_addr", fetch_addr_q, 16'h0502);
    chk("fetch_req", 16'(fetch_req_q), 16'h0);
    index_reg = 8'hff;
    run(16'h0500, 8'he6, 8'h80, 8'h00);
    chk("ea", eff_addr_q, 16'h017f);
    slow = 2'h0;
  endtask

  // taken branches at both ends of the reach, not-taken at the forward end, and the irq pin branches
  task automatic t_rel();
    logic [7:0] op [6] = '{8'h26, 8'h26, 8'h26, 8'h2e, 8'h2f, 8'h2f};
    logic [7:0] of [6] = '{8'h80, 8'h7f, 8'h7f, 8'h10, 8'h10, 8'h10};
    logic       ct [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    logic [15:0] np [6] = '{16'h0182, 16'h0281, 16'h0202, 16'h0212, 16'h0202, 16'h0212};
    for (int k = 0; k < 6; k++) begin
      cond_true = ct[k];
      irq_pin = ct[k];
      run(16'h0200, op[k], of[k], 8'h00);
      ins(2'h2, 4'h3, cad_pkg::AM_REL, np[k]);
    end
  endtask

  // all sixteen set and clear opcodes, both ops on each of the eight bits
  task automatic t_bsc();
    for (int n = 0; n < 8; n++) begin
      for (int s = 0; s < 2; s++) begin
        run(16'h0600, 8'h10 + 8'(2 * n + s), 8'h80 + 8'(n), 8'h00);
        ins(2'h2, 4'h5, cad_pkg::AM_BSC, 16'h0602);
        chk("ea", eff_addr_q, 16'h0080 + 16'(n));
        chk("bit", 16'(bit_num_q), 16'(n));
        chk("set", 16'(bit_set_op_q), 16'(s == 0));
      end
    end
  endtask

  // test-and-branch on every bit, bit high and low
  task automatic t_btb();
    for (int n = 0; n < 8; n++) begin
      for (int s = 0; s < 2; s++) begin
        for (int v = 0; v < 2; v++) begin
          bit_byte = (v == 1) ? 8'(1 << n) : ~8'(1 << n);
          run(16'h0700, 8'(2 * n + s), 8'h20, 8'hf0);
          ins(2'h3, 4'h5, cad_pkg::AM_BTB, (v == (s == 0)) ? 16'h06f3 : 16'h0703);
          chk("carry", 16'(carry_val_q), 16'(v));
          chk("carry_we", 16'(carry_we_q), 16'h1);
        end
      end
    end
  endtask

  // read-modify-write shift in every mode
  task automatic t_rmw();
    logic [7:0] op [5] = '{8'h47, 8'h57, 8'h37, 8'h77, 8'h67};
    logic [1:0] ln [5] = '{2'h1, 2'h1, 2'h2, 2'h1, 2'h2};
    logic [3:0] cy [5] = '{4'h3, 4'h3, 4'h5, 4'h5, 4'h6};
    cad_pkg::cad_mode_t md [5] = '{cad_pkg::AM_INH, cad_pkg::AM_INH, cad_pkg::AM_DIR,
                                   cad_pkg::AM_IX, cad_pkg::AM_IX1};
    for (int k = 0; k < 5; k++) begin
      run(16'h0900, op[k], 8'h12, 8'h00);
      ins(ln[k], cy[k], md[k], 16'h0900 + 16'(ln[k]));
    end
  endtask

  // control opcodes, subroutine branch, an unassigned code
  task automatic t_ctl();
    logic [7:0] op [11] = '{8'h97, 8'h9f, 8'h99, 8'h98, 8'h9b, 8'h9a, 8'h9c, 8'h9d,
                            8'h80, 8'h81, 8'h83};
    logic [3:0] cy [11] = '{4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2,
                            4'h9, 4'h6, 4'ha};
    for (int k = 0; k < 11; k++) begin
      run(16'h0800, op[k], 8'h00, 8'h00);
      ins(2'h1, cy[k], cad_pkg::AM_INH, 16'h0801);
      chk("undef", 16'(undefined_q), 16'h0);
    end
    run(16'h0800, 8'had, 8'h04, 8'h00);
    chk("length", 16'(length_q), 16'h2);
    chk("cycles", 16'(cycles_q), 16'h6);
    chk("ea", eff_addr_q, 16'h0806);
    run(16'h0800, 8'h9e, 8'h00, 8'h00);
    chk("undef", 16'(undefined_q), 16'h1);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    #1 sys_rst = 1'b0;
    t_modes();
    t_index();
    t_rel();
    t_bsc();
    t_btb();
    t_rmw();
    t_ctl();
    report_and_stop();
  end
endmodule
